// ### rtl/rcs_pkg.sv
// Package for the reset cause sequencer: register map, fields, timing.
// Assumes a 100 MHz system clock and a word-addressed Avalon-MM slave.
package rcs_pkg;

  localparam int unsigned CLK_HZ = 100_000_000;

  // Register word addresses (byte address = 4 * index)
  localparam logic [3:0] IDX_STATUS_CTRL = 4'h0;
  localparam logic [3:0] IDX_CLOCK_CFG = 4'h1;
  localparam logic [3:0] IDX_WATCHDOG = 4'h2;
  localparam logic [3:0] IDX_SUPERVISOR = 4'h3;

  // Status/control fields
  localparam int unsigned BIT_RUN = 0;
  localparam int unsigned BIT_SLEEP = 3;
  localparam int unsigned BIT_POR_FLAG = 4;
  localparam int unsigned BIT_WDT_FLAG = 5;
  localparam logic [7:0] SCR_POR_VALUE = 8'h11;
  localparam logic [7:0] SCR_WRITE_MASK = 8'h39;

  // Clock configuration fields
  localparam int unsigned BIT_CLK_EXT = 0;
  localparam int unsigned POS_DIV = 1;
  localparam int unsigned POS_INTERVAL = 4;
  localparam logic [2:0] DIV_BY_8 = 3'h3;
  localparam logic [1:0] INTERVAL_MIN = 2'h0;
  localparam logic CLK_INTERNAL = 1'b0;

  localparam logic [15:0] FETCH_RESET_ADDR = 16'h0000;

  // Timing in their own units
  localparam int unsigned HOLD_OFF_MS = 64;
  localparam int unsigned PIN_MIN_MS = 1;
  localparam int unsigned WD_KICK = 8'h38;
  localparam int unsigned HOLD_OFF_CYC = HOLD_OFF_MS * (CLK_HZ / 1000);
  localparam int unsigned PIN_MIN_CYC = PIN_MIN_MS * (CLK_HZ / 1000);

  typedef enum logic [1:0] {
    RCS_ST_RESET,
    RCS_ST_HOLD,
    RCS_ST_RUN
  } rcs_state_e;

  typedef struct packed {
    logic ext_clk_sel;
    logic [2:0] div_sel;
    logic [1:0] interval_sel;
  } rcs_clkcfg_s;

endpackage

// ### rtl/rcs_counter.sv
// Cycle counter with restart; flags when a target count is reached.
// Assumes the caller holds restart high to clear it.
module rcs_counter #(
  parameter int unsigned WIDTH = 24
) (
  input wire logic clock_i, // System clock
  input wire logic srst_i, // Synchronous reset
  input wire logic restart_i, // Clear count
  input wire logic run_i, // Count while high
  input wire logic [WIDTH-1:0] target_i, // Terminal count
  output logic done_o // Count reached target
);

  logic [WIDTH-1:0] cnt_ff;
  logic [WIDTH-1:0] nxt_cnt;
  logic done_ff;
  logic nxt_done;

  always_comb begin
    nxt_cnt = cnt_ff;
    nxt_done = done_ff;
    if (restart_i) begin
      nxt_cnt = '0;
      nxt_done = 1'b0;
    end else if (run_i && !done_ff) begin
      nxt_cnt = cnt_ff + 1'b1;
      nxt_done = (cnt_ff + 1'b1) >= target_i;
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      cnt_ff <= '0;
      done_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      done_ff <= nxt_done;
    end
  end

  assign done_o = done_ff;

endmodule

// ### rtl/rcs_sync.sv
// Two flip-flop synchroniser for an asynchronous level input.
// Assumes the input level is slow compared with the clock.
module rcs_sync (
  input wire logic clock_i, // System clock
  input wire logic srst_i, // Synchronous reset
  input wire logic async_i, // Asynchronous level
  output logic sync_o // Synchronised level
);

  logic meta_ff;
  logic sync_ff;

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
    end else begin
      meta_ff <= async_i;
      sync_ff <= meta_ff;
    end
  end

  assign sync_o = sync_ff;

endmodule

// ### rtl/rcs_top.sv
// Reset cause sequencer: gathers power-up, pin and watchdog resets,
// holds the core off after power-up and keeps the cause register.
// Assumes power-up and pin inputs are asynchronous levels, watchdog
// expiry is a one-cycle pulse on this clock, and Avalon-MM software.
//
// Decided for this implementation: the Avalon-MM slave port and the placing of the registers.
module rcs_top #(
  parameter int unsigned HOLD_CYC = rcs_pkg::HOLD_OFF_CYC,
  parameter int unsigned PIN_CYC = rcs_pkg::PIN_MIN_CYC
) (
  input wire logic clock_i, // System clock
  input wire logic srst_i, // Synchronous reset
  input wire logic power_up_i, // Supply trip level, high = in reset
  input wire logic reset_pin_i, // External reset pin level
  input wire logic watchdog_reset_event_i, // Watchdog expiry pulse
  input wire logic irq_pending_i, // Any interrupt pending, wakes core
  input wire logic [3:0] avs_address, // Word address
  input wire logic avs_read, // Read request
  input wire logic avs_write, // Write request
  input wire logic [31:0] avs_writedata, // Write data
  input wire logic [3:0] avs_byteenable, // Byte lanes
  output logic [31:0] avs_readdata, // Read data
  output logic avs_waitrequest, // Stall
  output logic [1:0] avs_response, // 00 okay, 10 slave error
  output logic core_reset_o, // Core held in reset
  output logic core_run_o, // Core may execute
  output logic core_sleep_o, // Core is asleep
  output logic irq_enable_o, // Interrupts may be enabled
  output logic [15:0] fetch_addr_o, // Start fetch address
  output logic ext_clk_sel_o, // External clock chosen
  output logic [2:0] clk_div_o, // Core clock divider code
  output logic [1:0] interval_sel_o, // Sleep/watchdog interval
  output logic watchdog_enable_o // Watchdog armed
);

  logic por_sync;
  logic pin_sync;
  logic pin_long;
  logic hold_done;
  logic por_src;
  logic any_reset;
  logic wd_fire;
  logic wr_scr;
  logic wr_clk;
  logic [7:0] wbyte;
  logic wait_ff;
  logic nxt_wait;
  logic [15:0] fetch_ff;
  logic [15:0] nxt_fetch;
  logic nxt_core_reset;
  logic nxt_core_run;
  logic nxt_core_sleep;
  logic nxt_irq_en;

  rcs_pkg::rcs_state_e state_ff;
  rcs_pkg::rcs_state_e nxt_state;
  logic [7:0] scr_ff;
  logic [7:0] nxt_scr;
  rcs_pkg::rcs_clkcfg_s cfg_ff;
  rcs_pkg::rcs_clkcfg_s nxt_cfg;
  logic wd_en_ff;
  logic nxt_wd_en;
  logic ack_ff;
  logic nxt_ack;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic [1:0] resp_ff;
  logic [1:0] nxt_resp;
  logic core_reset_ff;
  logic core_run_ff;
  logic core_sleep_ff;
  logic irq_en_ff;

  // Strobe for a register write to one word index
  function automatic logic write_hits(
    input logic wr,
    input logic acked,
    input logic lane0,
    input logic [3:0] addr,
    input logic [3:0] idx
  );
    return wr && acked && lane0 && (addr == idx);
  endfunction

  // Clock configuration packed into the byte that software sees
  function automatic logic [7:0] cfg_to_byte(
    input rcs_pkg::rcs_clkcfg_s cfg
  );
    logic [7:0] b;
    b = 8'h00;
    b[rcs_pkg::BIT_CLK_EXT] = cfg.ext_clk_sel;
    b[rcs_pkg::POS_DIV +: 3] = cfg.div_sel;
    b[rcs_pkg::POS_INTERVAL +: 2] = cfg.interval_sel;
    return b;
  endfunction

  rcs_sync u_por_sync (
    .clock_i(clock_i),
    .srst_i(srst_i),
    .async_i(power_up_i),
    .sync_o(por_sync)
  );

  rcs_sync u_pin_sync (
    .clock_i(clock_i),
    .srst_i(srst_i),
    .async_i(reset_pin_i),
    .sync_o(pin_sync)
  );

  // Pin must stay high the whole qualifying time; glitches restart it
  rcs_counter #(.WIDTH(24)) u_pin_cnt (
    .clock_i(clock_i),
    .srst_i(srst_i),
    .restart_i(!pin_sync),
    .run_i(pin_sync),
    .target_i(24'(PIN_CYC)),
    .done_o(pin_long)
  );

  // Hold-off counter runs only once the power-up source has gone away
  rcs_counter #(.WIDTH(24)) u_hold_cnt (
    .clock_i(clock_i),
    .srst_i(srst_i),
    .restart_i(state_ff != rcs_pkg::RCS_ST_HOLD),
    .run_i(1'b1),
    .target_i(24'(HOLD_CYC)),
    .done_o(hold_done)
  );

  assign por_src = por_sync || pin_long;
  // Watchdog is only honoured once armed, i.e. power-up flag cleared
  assign wd_fire = watchdog_reset_event_i && wd_en_ff;
  assign any_reset = srst_i || por_src || wd_fire;
  assign wbyte = avs_writedata[7:0];
  // Writes land at the edge that completes the transfer, not before
  assign wr_scr = write_hits(avs_write, ack_ff, avs_byteenable[0],
                             avs_address, rcs_pkg::IDX_STATUS_CTRL);
  assign wr_clk = write_hits(avs_write, ack_ff, avs_byteenable[0],
                             avs_address, rcs_pkg::IDX_CLOCK_CFG);

  // Sequencer
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      rcs_pkg::RCS_ST_RESET: begin
        if (!por_src) begin
          nxt_state = rcs_pkg::RCS_ST_HOLD;
        end
      end
      rcs_pkg::RCS_ST_HOLD: begin
        if (hold_done) begin
          nxt_state = rcs_pkg::RCS_ST_RUN;
        end
      end
      rcs_pkg::RCS_ST_RUN: begin
        nxt_state = rcs_pkg::RCS_ST_RUN;
      end
      default: begin
        // Unused code: fall back to a full reset sequence
        nxt_state = rcs_pkg::RCS_ST_RESET;
      end
    endcase
    if (por_src) begin
      nxt_state = rcs_pkg::RCS_ST_RESET;
    end else if (wd_fire) begin
      // Watchdog resets the core but skips the supply hold-off
      nxt_state = rcs_pkg::RCS_ST_RUN;
    end
  end

  // Status/control, clock configuration and watchdog arming
  always_comb begin
    nxt_scr = scr_ff;
    nxt_cfg = cfg_ff;
    nxt_wd_en = wd_en_ff;
    if (wr_scr) begin
      // Flags take only clears; sleep and run take the written value
      nxt_scr[rcs_pkg::BIT_WDT_FLAG] = scr_ff[rcs_pkg::BIT_WDT_FLAG]
        & wbyte[rcs_pkg::BIT_WDT_FLAG];
      nxt_scr[rcs_pkg::BIT_POR_FLAG] = scr_ff[rcs_pkg::BIT_POR_FLAG]
        & wbyte[rcs_pkg::BIT_POR_FLAG];
      nxt_scr[rcs_pkg::BIT_SLEEP] = wbyte[rcs_pkg::BIT_SLEEP];
      nxt_scr[rcs_pkg::BIT_RUN] = wbyte[rcs_pkg::BIT_RUN];
    end
    if (wr_clk) begin
      nxt_cfg.ext_clk_sel = wbyte[rcs_pkg::BIT_CLK_EXT];
      nxt_cfg.div_sel = wbyte[rcs_pkg::POS_DIV +: 3];
      nxt_cfg.interval_sel = wbyte[rcs_pkg::POS_INTERVAL +: 2];
    end
    // Wake on any interrupt
    if (irq_pending_i) begin
      nxt_scr[rcs_pkg::BIT_SLEEP] = 1'b0;
    end
    // Arming is one-way; nothing but a power-up, pin or synchronous reset disarms it
    if (!nxt_scr[rcs_pkg::BIT_POR_FLAG]) begin
      nxt_wd_en = 1'b1;
    end
    nxt_scr = nxt_scr & rcs_pkg::SCR_WRITE_MASK;
    if (por_src) begin
      nxt_scr = rcs_pkg::SCR_POR_VALUE;
      nxt_cfg.div_sel = rcs_pkg::DIV_BY_8;
      nxt_cfg.ext_clk_sel = rcs_pkg::CLK_INTERNAL;
      nxt_cfg.interval_sel = rcs_pkg::INTERVAL_MIN;
      nxt_wd_en = 1'b0;
    end else if (wd_fire) begin
      // Set wins over a same-cycle clear; divider keeps its setting
      nxt_scr = rcs_pkg::SCR_POR_VALUE & ~(8'h1 << rcs_pkg::BIT_POR_FLAG);
      nxt_scr[rcs_pkg::BIT_WDT_FLAG] = 1'b1;
      nxt_cfg.ext_clk_sel = rcs_pkg::CLK_INTERNAL;
      nxt_cfg.interval_sel = rcs_pkg::INTERVAL_MIN;
    end
  end

  // Bus slave: one wait cycle, then acknowledge
  always_comb begin
    nxt_ack = 1'b0;
    nxt_wait = 1'b1;
    nxt_rdata = rdata_ff;
    nxt_resp = resp_ff;
    if ((avs_read || avs_write) && !ack_ff) begin
      nxt_ack = 1'b1;
      nxt_wait = 1'b0;
      nxt_resp = 2'h0;
      nxt_rdata = 32'h0000_0000;
      unique case (avs_address)
        rcs_pkg::IDX_STATUS_CTRL: nxt_rdata = {24'h000000, scr_ff};
        rcs_pkg::IDX_CLOCK_CFG: begin
          nxt_rdata = {24'h000000, cfg_to_byte(cfg_ff)};
        end
        rcs_pkg::IDX_WATCHDOG: nxt_rdata = {31'h0, wd_en_ff};
        rcs_pkg::IDX_SUPERVISOR: nxt_rdata = {30'h0, state_ff};
        default: nxt_resp = 2'h2;
      endcase
      if (!avs_read) begin
        nxt_rdata = 32'h0000_0000;
      end
    end
  end

  // Core control and fetch address, decided from the next state
  always_comb begin
    nxt_fetch = rcs_pkg::FETCH_RESET_ADDR;
    // Core held in reset, interrupts off, while any source acts
    nxt_core_reset = any_reset
                     || (nxt_state != rcs_pkg::RCS_ST_RUN);
    nxt_irq_en = !any_reset
                 && (nxt_state == rcs_pkg::RCS_ST_RUN);
    nxt_core_run = (nxt_state == rcs_pkg::RCS_ST_RUN)
                   && !nxt_scr[rcs_pkg::BIT_SLEEP];
    nxt_core_sleep = (nxt_state == rcs_pkg::RCS_ST_RUN)
                     && nxt_scr[rcs_pkg::BIT_SLEEP];
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      state_ff <= rcs_pkg::RCS_ST_RESET;
    end else begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      scr_ff <= rcs_pkg::SCR_POR_VALUE;
      cfg_ff <= '{rcs_pkg::CLK_INTERNAL, rcs_pkg::DIV_BY_8,
                  rcs_pkg::INTERVAL_MIN};
      wd_en_ff <= 1'b0;
    end else begin
      scr_ff <= nxt_scr;
      cfg_ff <= nxt_cfg;
      wd_en_ff <= nxt_wd_en;
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      ack_ff <= 1'b0;
      wait_ff <= 1'b1;
      rdata_ff <= 32'h0000_0000;
      resp_ff <= 2'h0;
    end else begin
      ack_ff <= nxt_ack;
      wait_ff <= nxt_wait;
      rdata_ff <= nxt_rdata;
      resp_ff <= nxt_resp;
    end
  end

  // Fetch address is a register so that every output leaves a flop
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      core_reset_ff <= 1'b1;
      core_run_ff <= 1'b0;
      core_sleep_ff <= 1'b0;
      irq_en_ff <= 1'b0;
      fetch_ff <= rcs_pkg::FETCH_RESET_ADDR;
    end else begin
      core_reset_ff <= nxt_core_reset;
      core_run_ff <= nxt_core_run;
      core_sleep_ff <= nxt_core_sleep;
      irq_en_ff <= nxt_irq_en;
      fetch_ff <= nxt_fetch;
    end
  end

  assign avs_readdata = rdata_ff;
  assign avs_waitrequest = wait_ff;
  assign avs_response = resp_ff;
  assign core_reset_o = core_reset_ff;
  assign core_run_o = core_run_ff;
  assign core_sleep_o = core_sleep_ff;
  assign irq_enable_o = irq_en_ff;
  assign fetch_addr_o = fetch_ff;
  assign ext_clk_sel_o = cfg_ff.ext_clk_sel;
  assign clk_div_o = cfg_ff.div_sel;
  assign interval_sel_o = cfg_ff.interval_sel;
  assign watchdog_enable_o = wd_en_ff;

endmodule

// ### verif/rcs_properties.sv
// Checker for the reset cause sequencer top: bus and reset outputs.
// Assumes it is bound to rcs_top and sees only its ports.
module rcs_properties (
  input wire logic clock_i, // Clock
  input wire logic srst_i, // Reset
  input wire logic power_up_i, // Supply trip
  input wire logic reset_pin_i, // Pin level
  input wire logic watchdog_reset_event_i, // Expiry pulse
  input wire logic irq_pending_i, // Wake
  input wire logic [3:0] avs_address, // Index
  input wire logic avs_read, // Read
  input wire logic avs_write, // Write
  input wire logic [31:0] avs_readdata, // Read data
  input wire logic avs_waitrequest, // Stall
  input wire logic [1:0] avs_response, // Response
  input wire logic core_reset_o, // Core reset
  input wire logic core_run_o, // Core runs
  input wire logic core_sleep_o, // Core sleeps
  input wire logic irq_enable_o, // Irq enable
  input wire logic [15:0] fetch_addr_o, // Fetch address
  input wire logic ext_clk_sel_o, // Clock select
  input wire logic [2:0] clk_div_o, // Divider
  input wire logic [1:0] interval_sel_o, // Interval
  input wire logic watchdog_enable_o // Armed
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (srst_i);
  a_fetch_zero: assert property (fetch_addr_o == 16'h0000)
    else $error("fetch address moved");
  a_reset_core: assert property ($fell(srst_i) |-> core_reset_o
    && !irq_enable_o) else $error("core not held after reset");
  a_reset_cfg: assert property ($fell(srst_i) |->
    clk_div_o == rcs_pkg::DIV_BY_8 && !ext_clk_sel_o
    && interval_sel_o == 2'h0 && !watchdog_enable_o)
    else $error("clock defaults wrong after reset");
  a_bus_answer: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest) else $error("no answer in one cycle");
  a_ack_single: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("answer stood too long");
  a_unmapped_err: assert property (avs_read && avs_waitrequest
    && avs_address > 4'h3 |=> avs_response == 2'h2 && avs_readdata == 32'h0)
    else $error("unmapped read not refused");
  a_reserved_zero: assert property (!avs_waitrequest
    && avs_address == 4'h0 |-> avs_readdata[7:6] == 2'h0
    && avs_readdata[2:1] == 2'h0) else $error("reserved bits not zero");
  a_no_early_wd: assert property (watchdog_reset_event_i
    && !watchdog_enable_o && core_run_o |=> !core_reset_o)
    else $error("watchdog reset while not armed");
  a_wd_resets: assert property (watchdog_reset_event_i
    && watchdog_enable_o |=> core_reset_o && !irq_enable_o)
    else $error("armed watchdog did not reset core");
  a_wd_latched: assert property ($fell(watchdog_enable_o) |->
    $past(srst_i) || $past(reset_pin_i, 3) || $past(power_up_i, 3))
    else $error("watchdog disarmed without power-up");
  a_sleep_wake: assert property (irq_pending_i && core_sleep_o
    |-> ##[1:3] !core_sleep_o) else $error("core did not wake");
  c_sleep: cover property ($rose(core_sleep_o));
  c_armed: cover property ($rose(watchdog_enable_o));
  c_refused: cover property (avs_response == 2'h2);
  c_wd_reset: cover property (watchdog_reset_event_i && watchdog_enable_o);
endmodule

// ### verif/tb.sv
// Self-checking bench for rcs_top with short hold and pin counts.
// Assumes a 100 MHz clock and an Avalon-MM master driven here.
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int HOLD = 20;
  localparam int PIN = 10;
  logic clock_i = 1'b0;
  logic srst_i = 1'b1;
  logic power_up_i = 1'b1;
  logic reset_pin_i = 1'b0;
  logic watchdog_reset_event_i = 1'b0;
  logic irq_pending_i = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [1:0] avs_response;
  logic core_reset_o, core_run_o, core_sleep_o, irq_enable_o;
  logic ext_clk_sel_o, watchdog_enable_o;
  logic [15:0] fetch_addr_o;
  logic [2:0] clk_div_o;
  logic [1:0] interval_sel_o;
  logic [33:0] exp_q [$];
  logic [31:0] rnd;
  int failures = 0;
  int comparisons = 0;
  int cnt;

  always #5 clock_i = ~clock_i;

  rcs_top #(.HOLD_CYC(HOLD), .PIN_CYC(PIN)) u_rcs_top (.*);

  task automatic print_verdict();
    if (failures == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clock_i);
  endtask

  // Request held until waitrequest is sampled low; reads note a result
  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [31:0] d, input logic [33:0] e);
    int i;
    @(posedge clock_i);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    if (!wr) exp_q.push_back(e);
    for (i = 0; i < 20; i++) begin
      @(posedge clock_i);
      if (avs_waitrequest === 1'b0) break;
    end
    if (i == 20) begin
      failures++;
      print_verdict();
    end
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wait_run();
    int i;
    for (i = 0; i < 200 && core_run_o !== 1'b1; i++) @(posedge clock_i);
    cnt = i;
    if (i == 200) begin
      failures++;
      print_verdict();
    end
  endtask

  task automatic pulse_wd();
    watchdog_reset_event_i <= 1'b1;
    cyc(1);
    watchdog_reset_event_i <= 1'b0;
  endtask

  always @(posedge clock_i) begin
    if (avs_read && avs_waitrequest === 1'b0) begin
      if (exp_q.size() == 0) failures++;
      else check({avs_response, avs_readdata}, exp_q.pop_front());
    end
  end

  initial begin
    rnd = $urandom(34);
    cyc(4);
    srst_i <= 1'b0;
    power_up_i <= 1'b0;
    wait_run();
    check(34'(cnt >= HOLD && cnt <= HOLD + 6), 34'h1);
    check(34'({core_reset_o, irq_enable_o}), 34'h1);
    check(34'(fetch_addr_o), 34'(rcs_pkg::FETCH_RESET_ADDR));
    bus(0, 4'h3, 0, 34'h2);
    bus(0, 4'h0, 0, 34'h11);
    bus(0, 4'h1, 0, 34'h06);
    bus(0, 4'h2, 0, 34'h0);
    // Lane 0 off: this clear must not land
    avs_byteenable <= 4'h0;
    bus(1, 4'h0, 32'h0, 0);
    avs_byteenable <= 4'hF;
    bus(1, 4'h0, 32'hFF, 0);
    bus(0, 4'h0, 0, 34'h19);
    check(34'(core_sleep_o), 34'h1);
    irq_pending_i <= 1'b1;
    cyc(1);
    irq_pending_i <= 1'b0;
    bus(0, 4'h0, 0, 34'h11);
    pulse_wd();
    cyc(1);
    check(34'(core_reset_o), 34'h0);
    bus(0, 4'h0, 0, 34'h11);
    bus(1, 4'h0, 32'h1, 0);
    bus(0, 4'h2, 0, 34'h1);
    rnd = $urandom();
    bus(1, 4'h1, rnd, 0);
    bus(0, 4'h1, 0, 34'(rnd[5:0]));
    check(34'(ext_clk_sel_o), 34'(rnd[0]));
    check(34'(clk_div_o), 34'(rnd[3:1]));
    check(34'(interval_sel_o), 34'(rnd[5:4]));
    bus(1, 4'h2, 32'h0, 0);
    pulse_wd();
    cyc(1);
    check(34'(core_reset_o), 34'h1);
    bus(0, 4'h0, 0, 34'h21);
    bus(0, 4'h1, 0, 34'({rnd[3:1], 1'b0}));
    bus(0, 4'h2, 0, 34'h1);
    bus(1, 4'h0, 32'h1, 0);
    bus(0, 4'h0, 0, 34'h1);
    bus(1, 4'hC, 32'hFF, 0);
    bus(0, 4'h9, 0, 34'h2_0000_0000);
    reset_pin_i <= 1'b1;
    cyc(PIN + 8);
    reset_pin_i <= 1'b0;
    wait_run();
    check(34'(cnt >= HOLD), 34'h1);
    bus(0, 4'h0, 0, 34'h11);
    bus(0, 4'h1, 0, 34'h06);
    check(34'(watchdog_enable_o), 34'h0);
    cyc(2);
    check(34'(exp_q.size()), 34'h0);
    print_verdict();
  end
endmodule

bind rcs_top rcs_properties u_rcs_properties (.*);
